// file: hw/paged_config_register_bank.sv
// general configuration register bank with paged digital bank and top-page power controls
// How it works
// - three byte registers form a 24-bit bank selector choosing main, function or link pages
// - function page codes for either channel map that page into bank accesses
// - serial_wire_mode bit 0 picks 4-wire (0) or 3-wire shared data pin (1)
// - converter selector all ones selects converter page; top selector must be clear
// - top_page_select bit 2 opens the top page; converter selector must be zero
// - power-down bit 4 turns off the timing reference buffer and drops its pulses
// - power-down bit 1 powers down channel B; clear means normal operation
// - power-down bit 0 gives global power-down; clearing restores normal operation
// - register 002h holds selector bits 7 to 0, read/write, reset zero
// - channel B power-down acts only with the allow bit of register 039h set
// - soft reset only when bits 7 and 0 of 000h written together; self-clearing
`include "cfg_bank_map.svh"

module paged_config_register_bank (
  input wire logic clock,
  input wire logic arst_n,
  input wire logic sclk,
  input wire logic sen_n,
  input wire logic serial_data_io_in,
  output logic serial_data_io_out,
  output logic serial_data_io_oe,
  output logic sdout,
  output logic sdout_oe,
  output cfg_bank_pkg::bank_req_t bank_req,
  input wire logic [7:0] bank_rdata,
  output cfg_bank_pkg::page_id_t link_bank_page_selector,
  input wire logic timing_ref_in,
  output logic timing_ref_out,
  output cfg_bank_pkg::power_ctl_t power,
  output logic three_wire_mode,
  output logic converter_page_active,
  output logic top_page_active,
  output logic soft_reset
);

  // page selector decode, shared by the bank request path and the page output
  function automatic cfg_bank_pkg::page_id_t page_decode(input logic [23:0] code);
    unique case (code)
      `PAGE_MAIN_A: page_decode = cfg_bank_pkg::page_main_a;
      `PAGE_MAIN_B: page_decode = cfg_bank_pkg::page_main_b;
      `PAGE_FUNC_A: page_decode = cfg_bank_pkg::page_func_a;
      `PAGE_FUNC_B: page_decode = cfg_bank_pkg::page_func_b;
      `PAGE_LINK: page_decode = cfg_bank_pkg::page_link;
      default: page_decode = cfg_bank_pkg::page_none;
    endcase
  endfunction

  cfg_bank_pkg::frame_cmd_t cmd;
  logic cmd_valid, rd_load, wr_valid, sdo, read_phase;
  logic [7:0] wdata;
  logic [7:0] rd_data;

  logic [7:0] page_low_ff, page_mid_ff, page_high_ff;
  logic wire_mode_ff;
  logic [7:0] conv_page_ff;
  logic top_page_ff;
  logic ref_off_ff, chan_b_pdn_ff, whole_chip_powerdown_ff;
  logic bias_raise_ff, chan_b_allow_ff, sync_term_ff;
  logic soft_reset_ff, timing_ref_ff;
  cfg_bank_pkg::power_ctl_t power_ff;
  cfg_bank_pkg::bank_req_t bank_req_ff;

  serial_frame_engine #(
    .CMD_BITS(`FRAME_CMD_BITS),
    .DATA_BITS(`FRAME_DATA_BITS)
  ) u_frame (
    .clock(clock),
    .arst_n(arst_n),
    .sclk(sclk),
    .sen_n(sen_n),
    .sdi(serial_data_io_in),
    .rdata(rd_data),
    .cmd(cmd),
    .cmd_valid(cmd_valid),
    .rd_load(rd_load),
    .wr_valid(wr_valid),
    .wdata(wdata),
    .sdo(sdo),
    .read_phase(read_phase)
  );

  // page decode and address qualification
  wire [23:0] page_code = {page_high_ff, page_mid_ff, page_low_ff};
  wire cfg_bank_pkg::page_id_t page_now = page_decode(page_code);
  wire page_ok = page_now != cfg_bank_pkg::page_none;
  wire top_ok = top_page_ff & (conv_page_ff == `CONV_PAGE_OFF);
  wire conv_on = (conv_page_ff == `CONV_PAGE_ON) & ~top_page_ff;
  wire reg_wr = wr_valid & ~cmd.bank;
  wire top_wr = reg_wr & top_ok;
  wire wr_reset = reg_wr & (cmd.addr == `OFS_SOFT_RESET);
  wire wr_page_low = reg_wr & (cmd.addr == `OFS_PAGE_LOW);
  wire wr_page_mid = reg_wr & (cmd.addr == `OFS_PAGE_MID);
  wire wr_page_high = reg_wr & (cmd.addr == `OFS_PAGE_HIGH);
  wire wr_wire_mode = reg_wr & (cmd.addr == `OFS_WIRE_MODE);
  wire wr_conv_page = reg_wr & (cmd.addr == `OFS_CONV_PAGE);
  wire wr_top_page = reg_wr & (cmd.addr == `OFS_TOP_PAGE);
  wire wr_power = top_wr & (cmd.addr == `OFS_POWER_DOWN);
  wire wr_bias = top_wr & (cmd.addr == `OFS_INPUT_BIAS);
  wire wr_allow = top_wr & (cmd.addr == `OFS_PDN_ALLOW);
  // a lone bit 7 or bit 0 does nothing; both must land in one write
  wire soft_hit = wr_reset & wdata[`BIT_RESET_HI] & wdata[`BIT_RESET_LO];

  // read-back; reserved and write-only positions read zero, reset bits already cleared
  always_comb begin
    rd_data = `RST_BYTE;
    if (cmd.bank) begin
      rd_data = page_ok ? bank_rdata : `RST_BYTE;
    end else begin
      unique case (cmd.addr)
        `OFS_PAGE_LOW: rd_data = page_low_ff;
        `OFS_PAGE_MID: rd_data = page_mid_ff;
        `OFS_PAGE_HIGH: rd_data = page_high_ff;
        `OFS_WIRE_MODE: rd_data[`BIT_WIRE_MODE] = wire_mode_ff;
        `OFS_CONV_PAGE: rd_data = conv_page_ff;
        `OFS_TOP_PAGE: rd_data[`BIT_TOP_PAGE] = top_page_ff;
        `OFS_POWER_DOWN: begin
          if (top_ok) begin
            rd_data[`BIT_REF_OFF] = ref_off_ff;
            rd_data[`BIT_CHAN_B_PDN] = chan_b_pdn_ff;
            rd_data[`BIT_WHOLE_CHIP_POWERDOWN] = whole_chip_powerdown_ff;
          end
        end
        `OFS_INPUT_BIAS: rd_data[`BIT_BIAS_RAISE] = bias_raise_ff & top_ok;
        `OFS_PDN_ALLOW: begin
          rd_data[`BIT_CHAN_B_ALLOW] = chan_b_allow_ff & top_ok;
          rd_data[`BIT_SYNC_TERM] = sync_term_ff & top_ok;
        end
        default: rd_data = `RST_BYTE;
      endcase
    end
  end

  // general registers; the soft reset returns every field to its reset value
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      page_low_ff <= `RST_BYTE;
      page_mid_ff <= `RST_BYTE;
      page_high_ff <= `RST_BYTE;
      wire_mode_ff <= `RST_BIT;
      conv_page_ff <= `RST_BYTE;
      top_page_ff <= `RST_BIT;
    end else if (soft_hit) begin
      page_low_ff <= `RST_BYTE;
      page_mid_ff <= `RST_BYTE;
      page_high_ff <= `RST_BYTE;
      wire_mode_ff <= `RST_BIT;
      conv_page_ff <= `RST_BYTE;
      top_page_ff <= `RST_BIT;
    end else begin
      if (wr_page_low) page_low_ff <= wdata;
      if (wr_page_mid) page_mid_ff <= wdata;
      if (wr_page_high) page_high_ff <= wdata;
      if (wr_wire_mode) wire_mode_ff <= wdata[`BIT_WIRE_MODE];
      if (wr_conv_page) conv_page_ff <= wdata;
      if (wr_top_page) top_page_ff <= wdata[`BIT_TOP_PAGE];
    end
  end

  // top-page registers
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      ref_off_ff <= `RST_BIT;
      chan_b_pdn_ff <= `RST_BIT;
      whole_chip_powerdown_ff <= `RST_BIT;
      bias_raise_ff <= `RST_BIT;
      chan_b_allow_ff <= `RST_BIT;
      sync_term_ff <= `RST_BIT;
    end else if (soft_hit) begin
      ref_off_ff <= `RST_BIT;
      chan_b_pdn_ff <= `RST_BIT;
      whole_chip_powerdown_ff <= `RST_BIT;
      bias_raise_ff <= `RST_BIT;
      chan_b_allow_ff <= `RST_BIT;
      sync_term_ff <= `RST_BIT;
    end else begin
      if (wr_power) begin
        ref_off_ff <= wdata[`BIT_REF_OFF];
        chan_b_pdn_ff <= wdata[`BIT_CHAN_B_PDN];
        whole_chip_powerdown_ff <= wdata[`BIT_WHOLE_CHIP_POWERDOWN];
      end
      if (wr_bias) bias_raise_ff <= wdata[`BIT_BIAS_RAISE];
      if (wr_allow) begin
        chan_b_allow_ff <= wdata[`BIT_CHAN_B_ALLOW];
        sync_term_ff <= wdata[`BIT_SYNC_TERM];
      end
    end
  end

  // registered controls toward the converter; reset pulse is not itself cleared
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      power_ff <= '0;
      soft_reset_ff <= 1'b0;
      timing_ref_ff <= 1'b0;
    end else begin
      power_ff.whole_chip_powerdown <= whole_chip_powerdown_ff;
      power_ff.channel_b_powerdown <= chan_b_pdn_ff & chan_b_allow_ff;
      power_ff.timing_ref_buffer_off <= ref_off_ff;
      power_ff.common_mode_bias_raise <= bias_raise_ff;
      power_ff.sync_term_off <= sync_term_ff;
      soft_reset_ff <= soft_hit;
      timing_ref_ff <= timing_ref_in & ~ref_off_ff;
    end
  end

  // bank accesses leave as one-cycle requests tagged with the decoded page
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      bank_req_ff <= '{valid: 1'b0, write: 1'b0, page: cfg_bank_pkg::page_none,
                       addr: 12'h000, wdata: `RST_BYTE};
    end else begin
      bank_req_ff.valid <= cmd.bank & page_ok & ((cmd_valid & ~cmd.write) | wr_valid);
      bank_req_ff.write <= cmd.write;
      bank_req_ff.page <= page_now;
      bank_req_ff.addr <= cmd.addr;
      bank_req_ff.wdata <= wdata;
    end
  end

  // pin steering: 3-wire turns the data input pin around during read data
  assign serial_data_io_out = sdo;
  assign serial_data_io_oe = read_phase & wire_mode_ff;
  assign sdout = sdo;
  assign sdout_oe = read_phase & ~wire_mode_ff;
  assign bank_req = bank_req_ff;
  assign link_bank_page_selector = page_now;
  assign timing_ref_out = timing_ref_ff;
  assign power = power_ff;
  assign three_wire_mode = wire_mode_ff;
  assign converter_page_active = conv_on;
  assign top_page_active = top_ok;
  assign soft_reset = soft_reset_ff;

endmodule

// file: pkg/cfg_bank_map.svh
// register offsets, field positions, reset values and frame counts of the config bank
`ifndef CFG_BANK_MAP_SVH
`define CFG_BANK_MAP_SVH

// general registers, always decoded
`define OFS_SOFT_RESET 12'h000
`define OFS_PAGE_LOW 12'h002
`define OFS_PAGE_MID 12'h003
`define OFS_PAGE_HIGH 12'h004
`define OFS_WIRE_MODE 12'h010
`define OFS_CONV_PAGE 12'h011
`define OFS_TOP_PAGE 12'h012

// top-page registers, decoded only while the top page is open
`define OFS_POWER_DOWN 12'h020
`define OFS_INPUT_BIAS 12'h032
`define OFS_PDN_ALLOW 12'h039

// field positions
`define BIT_RESET_HI 7
`define BIT_RESET_LO 0
`define BIT_WIRE_MODE 0
`define BIT_TOP_PAGE 2
`define BIT_REF_OFF 4
`define BIT_CHAN_B_PDN 1
`define BIT_WHOLE_CHIP_POWERDOWN 0
`define BIT_BIAS_RAISE 5
`define BIT_CHAN_B_ALLOW 1
`define BIT_SYNC_TERM 0

// reset values
`define RST_BYTE 8'h00
`define RST_BIT 1'b0

// page codes of the 24-bit bank selector
`define PAGE_MAIN_A 24'h680000
`define PAGE_MAIN_B 24'h680100
`define PAGE_FUNC_A 24'h610000
`define PAGE_FUNC_B 24'h610100
`define PAGE_LINK 24'h690000

// converter page selector codes
`define CONV_PAGE_OFF 8'h00
`define CONV_PAGE_ON 8'hff

// serial frame: command bits then data bits, msb first
`define FRAME_CMD_BITS 16
`define FRAME_DATA_BITS 8
`define FRAME_BIT_READ 15
`define FRAME_BIT_BANK 14

`endif

// file: pkg/cfg_bank_pkg.sv
// types shared by the config register bank and its serial frame engine
package cfg_bank_pkg;

  typedef enum logic [5:0] {
    page_none   = 6'b000001,
    page_main_a = 6'b000010,
    page_main_b = 6'b000100,
    page_func_a = 6'b001000,
    page_func_b = 6'b010000,
    page_link   = 6'b100000
  } page_id_t;

  typedef struct packed {
    logic write;
    logic bank;
    logic [11:0] addr;
  } frame_cmd_t;

  typedef struct packed {
    logic valid;
    logic write;
    page_id_t page;
    logic [11:0] addr;
    logic [7:0] wdata;
  } bank_req_t;

  typedef struct packed {
    logic whole_chip_powerdown;
    logic channel_b_powerdown;
    logic timing_ref_buffer_off;
    logic common_mode_bias_raise;
    logic sync_term_off;
  } power_ctl_t;

endpackage

// file: hw/serial_frame_engine.sv
// serial frame engine: shifts command and data bits in, read data out
`include "cfg_bank_map.svh"

module serial_frame_engine #(
  parameter int CMD_BITS = `FRAME_CMD_BITS,
  parameter int DATA_BITS = `FRAME_DATA_BITS
) (
  input wire logic clock,
  input wire logic arst_n,
  input wire logic sclk,
  input wire logic sen_n,
  input wire logic sdi,
  input wire logic [7:0] rdata,
  output cfg_bank_pkg::frame_cmd_t cmd,
  output logic cmd_valid,
  output logic rd_load,
  output logic wr_valid,
  output logic [7:0] wdata,
  output logic sdo,
  output logic read_phase
);

  if (CMD_BITS != `FRAME_CMD_BITS || DATA_BITS != `FRAME_DATA_BITS) begin : g_chk
    $error("serial_frame_engine: only 16 command and 8 data bits are served");
  end

  typedef enum logic [2:0] {
    st_cmd  = 3'b001,
    st_data = 3'b010,
    st_hold = 3'b100
  } frame_st_t;

  localparam logic [4:0] CMD_LAST = 5'(CMD_BITS - 1);
  localparam logic [4:0] DATA_LAST = 5'(DATA_BITS - 1);

  frame_st_t state_ff, nxt_state;
  logic [4:0] cnt_ff, nxt_cnt;
  logic [15:0] sh_ff, nxt_sh;
  logic sclk_d_ff;
  logic nxt_cmd_valid;
  logic nxt_wr_valid;
  logic [7:0] out_sh_ff;
  logic cmd_valid_ff, rd_load_ff, wr_valid_ff, sdo_ff;
  cfg_bank_pkg::frame_cmd_t cmd_ff;
  logic [7:0] wdata_ff;

  // sclk is taken as synchronous; edges come from one delayed copy
  wire sclk_rise = sclk & ~sclk_d_ff;
  wire sclk_fall = ~sclk & sclk_d_ff;
  wire [15:0] shifted = {sh_ff[14:0], sdi};

  // frame sequencing; a high select aborts any frame at once
  always_comb begin
    nxt_state = state_ff;
    nxt_cnt = cnt_ff;
    nxt_sh = sh_ff;
    nxt_cmd_valid = 1'b0;
    nxt_wr_valid = 1'b0;
    if (sen_n) begin
      nxt_state = st_cmd;
      nxt_cnt = 5'h00;
    end else begin
      unique case (state_ff)
        st_cmd: begin
          if (sclk_rise) begin
            nxt_sh = shifted;
            nxt_cnt = cnt_ff + 5'h01;
            if (cnt_ff == CMD_LAST) begin
              nxt_state = st_data;
              nxt_cnt = 5'h00;
              nxt_cmd_valid = 1'b1;
            end
          end
        end
        st_data: begin
          if (sclk_rise) begin
            nxt_sh = shifted;
            nxt_cnt = cnt_ff + 5'h01;
            if (cnt_ff == DATA_LAST) begin
              nxt_state = st_hold;
              nxt_wr_valid = cmd_ff.write;
            end
          end
        end
        st_hold: nxt_state = st_hold; // extra clocks ignored until select rises
      endcase
    end
  end

  // state and shift registers
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      state_ff <= st_cmd;
      cnt_ff <= 5'h00;
      sh_ff <= 16'h0000;
      sclk_d_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      cnt_ff <= nxt_cnt;
      sh_ff <= nxt_sh;
      sclk_d_ff <= sclk;
    end
  end

  // command capture and strobes
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      cmd_ff <= '0;
      cmd_valid_ff <= 1'b0;
      rd_load_ff <= 1'b0;
      wr_valid_ff <= 1'b0;
      wdata_ff <= `RST_BYTE;
    end else begin
      cmd_valid_ff <= nxt_cmd_valid;
      rd_load_ff <= cmd_valid_ff;
      wr_valid_ff <= nxt_wr_valid;
      if (nxt_cmd_valid) begin
        cmd_ff <= '{write: ~shifted[`FRAME_BIT_READ], bank: shifted[`FRAME_BIT_BANK],
                    addr: shifted[11:0]};
      end
      if (nxt_wr_valid) begin
        wdata_ff <= nxt_sh[7:0];
      end
    end
  end

  // read data leaves on falling edges, so the host samples it on the next rise
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      out_sh_ff <= `RST_BYTE;
      sdo_ff <= 1'b0;
    end else if (sen_n) begin
      sdo_ff <= 1'b0;
    end else if (rd_load_ff) begin
      out_sh_ff <= rdata;
    end else if (sclk_fall && state_ff == st_data) begin
      sdo_ff <= out_sh_ff[7];
      out_sh_ff <= {out_sh_ff[6:0], 1'b0};
    end
  end

  assign cmd = cmd_ff;
  assign cmd_valid = cmd_valid_ff;
  assign rd_load = rd_load_ff;
  assign wr_valid = wr_valid_ff;
  assign wdata = wdata_ff;
  assign sdo = sdo_ff;
  assign read_phase = ~sen_n & ~cmd_ff.write & (state_ff == st_data || state_ff == st_hold);

endmodule

// file: testbench/spi_host_model.sv
// serial host model: frames of 16 command bits and 8 data bits, msb first
module spi_host_model (
  input wire logic clock,
  input wire logic sdo,
  output logic sclk,
  output logic sen_n,
  output logic sdi,
  output logic sdi_oe
);
  timeunit 1ns;
  timeprecision 100ps;
  localparam int HALF = 4; // clock cycles per half period, above the 3 the engine needs
  initial begin
    sclk = 1'b0;
    sen_n = 1'b1;
    sdi = 1'b0;
    sdi_oe = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  // nbits under 24 aborts the frame; sclk stands still low outside frames
  task automatic xfer(input logic [15:0] cmd, input logic [7:0] wdat, input int nbits,
                      output logic [7:0] rdat);
    logic [23:0] frame;
    frame = {cmd, wdat};
    rdat = 8'h00;
    tick(1);
    sen_n = 1'b0;
    for (int i = 23; i >= 24 - nbits; i--) begin
      sclk = 1'b0;
      sdi_oe = (i >= 8) || !cmd[15];
      // a read data phase gets a toggling pattern, never the last command bit
      sdi = sdi_oe ? frame[i] : i[0];
      tick(HALF);
      if (i < 8) rdat[i] = sdo;
      sclk = 1'b1;
      tick(HALF);
    end
    sclk = 1'b0;
    tick(HALF);
    sen_n = 1'b1;
    sdi_oe = 1'b0;
    tick(2);
  endtask
endmodule

// file: testbench/cfg_bank_sva.sv
// concurrent checks on the ports of the config register bank
module cfg_bank_sva (
  input wire logic clock,
  input wire logic arst_n,
  input wire logic sen_n,
  input wire logic sdout,
  input wire logic sdout_oe,
  input wire logic serial_data_io_oe,
  input wire logic timing_ref_in,
  input wire logic timing_ref_out,
  input wire cfg_bank_pkg::bank_req_t bank_req,
  input wire cfg_bank_pkg::power_ctl_t power,
  input wire logic three_wire_mode,
  input wire logic converter_page_active,
  input wire logic top_page_active,
  input wire logic soft_reset
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!arst_n);
  // the pin may only be driven by one side, and never outside frames
  sequence s_idle;
    sen_n [*3];
  endsequence
  a_oe_wire_mode: assert property (sdout_oe |-> !three_wire_mode) else $error("oe mode");
  a_oe_exclusive: assert property (!(sdout_oe && serial_data_io_oe)) else $error("oe both");
  a_oe_idle_low: assert property (s_idle |-> !sdout_oe && !serial_data_io_oe && !sdout)
    else $error("oe idle");
  a_pages_exclusive: assert property (top_page_active |-> !converter_page_active)
    else $error("pages");
  a_soft_pulse_once: assert property (soft_reset |=> !soft_reset) else $error("soft");
  a_soft_clears_regs: assert property (soft_reset |-> !three_wire_mode && !top_page_active
    ##1 power == '0) else $error("soft clear");
  a_ref_follows_in: assert property (timing_ref_out |-> $past(timing_ref_in))
    else $error("ref");
  a_ref_blocked: assert property (power.timing_ref_buffer_off &&
    $past(power.timing_ref_buffer_off) |-> !timing_ref_out) else $error("ref off");
  a_bank_page_set: assert property (bank_req.valid |-> bank_req.page != cfg_bank_pkg::page_none
    ##1 !bank_req.valid) else $error("bank req");
  cover property (soft_reset);
endmodule

bind paged_config_register_bank cfg_bank_sva u_sva (.clock(clock), .arst_n(arst_n),
  .sen_n(sen_n), .sdout(sdout), .sdout_oe(sdout_oe), .serial_data_io_oe(serial_data_io_oe),
  .timing_ref_in(timing_ref_in), .timing_ref_out(timing_ref_out), .bank_req(bank_req),
  .power(power), .three_wire_mode(three_wire_mode),
  .converter_page_active(converter_page_active), .top_page_active(top_page_active),
  .soft_reset(soft_reset));

// file: testbench/paged_config_register_bank_bench.sv
// register-level tests of the config register bank through its serial frame port
`include "cfg_bank_map.svh"
module paged_config_register_bank_bench;
  timeunit 1ns;
  timeprecision 100ps;
  logic clock = 1'b0;
  logic arst_n = 1'b0;
  logic sclk, sen_n, sdi, sdi_oe, sdi_line, host_sdo, timing_ref_in = 1'b1;
  logic serial_data_io_out, serial_data_io_oe, sdout, sdout_oe, timing_ref_out;
  logic three_wire_mode, converter_page_active, top_page_active, soft_reset;
  logic [7:0] bank_rdata, r;
  cfg_bank_pkg::bank_req_t bank_req, last_req;
  cfg_bank_pkg::page_id_t link_bank_page_selector;
  cfg_bank_pkg::power_ctl_t power;
  int failures = 0, checked = 0, cycles = 0, nreq = 0, nsoft = 0;
  always #10 clock = ~clock;
  // shared data pin: the device wins while enabled, a released line shows the inverse
  assign sdi_line = serial_data_io_oe ? serial_data_io_out : (sdi_oe ? sdi : ~sdi);
  assign host_sdo = three_wire_mode ? sdi_line : sdout;
  assign bank_rdata = bank_req.addr[7:0] ^ 8'ha5; // bank answers in the request cycle
  spi_host_model u_host (.clock(clock), .sdo(host_sdo), .sclk(sclk), .sen_n(sen_n),
    .sdi(sdi), .sdi_oe(sdi_oe));
  paged_config_register_bank u_dut (.clock(clock), .arst_n(arst_n), .sclk(sclk),
    .sen_n(sen_n), .serial_data_io_in(sdi_line), .serial_data_io_out(serial_data_io_out),
    .serial_data_io_oe(serial_data_io_oe), .sdout(sdout), .sdout_oe(sdout_oe),
    .bank_req(bank_req), .bank_rdata(bank_rdata),
    .link_bank_page_selector(link_bank_page_selector), .timing_ref_in(timing_ref_in),
    .timing_ref_out(timing_ref_out), .power(power), .three_wire_mode(three_wire_mode),
    .converter_page_active(converter_page_active), .top_page_active(top_page_active),
    .soft_reset(soft_reset));
  // bank request and soft reset pulses are counted here, never inferred from registers;
  // sampled on the falling edge so the launching rising edge cannot race the count
  always @(negedge clock) begin
    cycles++;
    if (bank_req.valid === 1'b1) begin
      last_req <= bank_req;
      nreq++;
    end
    if (soft_reset === 1'b1) nsoft++;
    if (cycles == 30000) begin
      failures++;
      stop_test();
    end
  end
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    u_host.xfer({4'h0, a}, d, 24, r);
  endtask
  task automatic rd(input logic bank, input logic [11:0] a, input logic [7:0] exp);
    u_host.xfer({1'b1, bank, 2'b00, a}, 8'h00, 24, r);
    chk("read data", {24'h0, exp}, {24'h0, r});
  endtask
  task automatic stop_test();
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  localparam logic [23:0] codes [6] = '{`PAGE_MAIN_A, `PAGE_MAIN_B, `PAGE_FUNC_A,
    `PAGE_FUNC_B, `PAGE_LINK, 24'h680200};
  localparam cfg_bank_pkg::page_id_t pages [6] = '{cfg_bank_pkg::page_main_a,
    cfg_bank_pkg::page_main_b, cfg_bank_pkg::page_func_a, cfg_bank_pkg::page_func_b,
    cfg_bank_pkg::page_link, cfg_bank_pkg::page_none};
  localparam logic [11:0] regs [7] = '{12'h002, 12'h003, 12'h004, 12'h010, 12'h011,
    12'h012, 12'h020};
  initial begin
    repeat (6) @(posedge clock);
    #1 arst_n = 1'b1;
    foreach (regs[i]) rd(1'b0, regs[i], 8'h00);
    chk("ref passes", 1, timing_ref_out);
    u_host.xfer({4'h0, `OFS_TOP_PAGE}, 8'h04, 20, r);
    chk("aborted write", 0, top_page_active);
    $display("test reset and abort done");
    for (int i = 0; i < 6; i++) begin
      wr(`OFS_PAGE_HIGH, codes[i][23:16]);
      wr(`OFS_PAGE_MID, codes[i][15:8]);
      wr(`OFS_PAGE_LOW, codes[i][7:0]);
      rd(1'b0, `OFS_PAGE_LOW, codes[i][7:0]);
      chk("page", {26'h0, pages[i]}, {26'h0, link_bank_page_selector});
    end
    rd(1'b1, 12'h006, 8'h00);
    chk("no bank req", 0, nreq);
    wr(`OFS_PAGE_HIGH, 8'h61);
    wr(`OFS_PAGE_MID, 8'h01);
    wr(`OFS_PAGE_LOW, 8'h00);
    u_host.xfer(16'h4006, 8'h80, 24, r);
    chk("bank write", {1'b1, 1'b1, cfg_bank_pkg::page_func_b, 12'h006, 8'h80}, last_req);
    rd(1'b1, 12'h035, 8'h90);
    chk("bank read", {1'b1, 1'b0, cfg_bank_pkg::page_func_b, 12'h035, 8'h00},
      {last_req[27:8], 8'h00});
    $display("test pages done");
    wr(`OFS_WIRE_MODE, 8'h01);
    chk("three wire", 1, three_wire_mode);
    rd(1'b0, `OFS_WIRE_MODE, 8'h01);
    wr(`OFS_WIRE_MODE, 8'h00);
    chk("four wire", 0, three_wire_mode);
    $display("test wire mode done");
    wr(`OFS_CONV_PAGE, `CONV_PAGE_ON);
    chk("conv page", 1, converter_page_active);
    rd(1'b0, `OFS_POWER_DOWN, 8'h00);
    wr(`OFS_CONV_PAGE, `CONV_PAGE_OFF);
    chk("conv off", 0, converter_page_active);
    $display("test converter page done");
    wr(`OFS_TOP_PAGE, 8'h04);
    chk("top page", 1, top_page_active);
    wr(`OFS_POWER_DOWN, 8'h13);
    chk("power", 5'b10100, power);
    chk("ref off", 0, timing_ref_out);
    rd(1'b0, `OFS_POWER_DOWN, 8'h13);
    wr(`OFS_PDN_ALLOW, 8'h52);
    chk("channel b allowed", 5'b11100, power);
    rd(1'b0, `OFS_PDN_ALLOW, 8'h02);
    wr(`OFS_INPUT_BIAS, 8'h20);
    rd(1'b0, `OFS_INPUT_BIAS, 8'h20);
    wr(`OFS_POWER_DOWN, 8'h00);
    chk("power up", 5'b00010, power);
    chk("ref back", 1, timing_ref_out);
    timing_ref_in = 1'b0;
    @(posedge clock);
    #1 chk("ref low", 0, timing_ref_out);
    timing_ref_in = 1'b1;
    wr(`OFS_POWER_DOWN, 8'h01);
    $display("test power done");
    wr(`OFS_SOFT_RESET, 8'h01);
    chk("half reset", 1, top_page_active);
    wr(`OFS_SOFT_RESET, 8'h81);
    chk("soft pulses", 1, nsoft);
    chk("cleared", 0, {top_page_active, power});
    rd(1'b0, `OFS_SOFT_RESET, 8'h00);
    $display("test soft reset done");
    stop_test();
  end
endmodule
